// *** core/gpdu_pkg.sv ***
// Package: constants and carriers for the gripper process-data unit
`default_nettype none
package gpdu_pkg;
  // Cyclic frame sizes in bytes
  localparam logic [1:0] CMD_BYTES = 2'd2;
  localparam logic [2:0] STAT_BYTES = 3'd4;
  // Event log window of parameter indices
  localparam logic [15:0] LOG_BASE_IDX = 16'h0100;
  localparam logic [15:0] LOG_LAST_IDX = 16'h0109;
  localparam int LOG_DEPTH = 10;
  // Temperature thresholds in degrees C
  localparam logic signed [7:0] WARN_LO_C = 8'sh00;
  localparam logic signed [7:0] WARN_HI_C = 8'sh37;
  localparam logic signed [7:0] WARN_HYST_C = 8'sh02;
  localparam logic signed [7:0] FAULT_SET_C = 8'sh46;
  localparam logic signed [7:0] FAULT_CLR_C = 8'sh44;
  // Service intervals in gripping cycles
  localparam logic [31:0] SERVICE_DUE_INTERVAL = 32'h0001_86A0;
  localparam logic [31:0] LUBE_INTERVAL = 32'h0000_C350;
  // Event codes stored in the log
  localparam logic [7:0] EVT_NONE = 8'h00;
  localparam logic [7:0] EVT_FAULT = 8'h01;
  localparam logic [7:0] EVT_OVERHEAT = 8'h02;
  localparam logic [7:0] EVT_DROPPED = 8'h03;
  localparam logic [7:0] EVT_SERVICE = 8'h04;
  localparam logic [7:0] EVT_LUBE = 8'h05;
  // Command word, MSB first
  typedef struct packed {
    logic [2:0] light_pattern_sel;
    logic retention_arm;
    logic spare_bit;
    logic ref_req;
    logic drive_en;
    logic grip_req;
    logic [7:0] grip_idx;
  } gpdu_cmd_t;
  // Status word, MSB first
  typedef struct packed {
    logic signed [15:0] jaw_pos;
    logic virtual_switch_three;
    logic virtual_switch_two;
    logic virtual_switch_one;
    logic virtual_switch_zero;
    logic workpiece_dropped;
    logic retention_ack;
    logic spare_bit;
    logic jaws_moving;
    logic service_due;
    logic thermal_warning;
    logic overheat_flag;
    logic dev_fault;
    logic holding;
    logic empty_grip_flag;
    logic released;
    logic inactive;
  } gpdu_stat_t;
  // Grip state, one-hot
  typedef enum logic [3:0] {
    ST_INACTIVE = 4'b0001,
    ST_RELEASED = 4'b0010,
    ST_NOPART = 4'b0100,
    ST_HOLDING = 4'b1000
  } gpdu_state_t;
endpackage : gpdu_pkg
`default_nettype wire

// *** core/gpdu_evlog.sv ***
// Ten-entry event log, newest entry at the lowest index
`default_nettype none
module gpdu_evlog
  import gpdu_pkg::*;
(
  input wire logic clk, // Device clock
  input wire logic rst, // Synchronous reset
  input wire logic evt_valid, // Event pulse
  input wire logic [7:0] evt_code, // Event code
  input wire logic [15:0] rd_index, // Parameter index
  output logic [7:0] rd_data, // Entry read back
  output logic rd_hit // Index inside the log window
);
  logic [7:0] ent_ff [LOG_DEPTH];
  logic [7:0] nxt_ent [LOG_DEPTH];
  logic [7:0] rd_ff;
  logic [7:0] nxt_rd;
  logic [15:0] rel;

  // Shift the log on each new event
  genvar g;
  generate
    for (g = 0; g < LOG_DEPTH; g++) begin : g_ent
      always_comb begin
        if (evt_valid) begin
          nxt_ent[g] = (g == 0) ? evt_code : ent_ff[(g == 0) ? 0 : g - 1]; // RULE_20
        end else begin
          nxt_ent[g] = ent_ff[g];
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          ent_ff[g] <= EVT_NONE;
        end else begin
          ent_ff[g] <= nxt_ent[g];
        end
      end
    end
  endgenerate

  // Index decode and registered read
  assign rel = rd_index - LOG_BASE_IDX;
  assign rd_hit = (rd_index >= LOG_BASE_IDX) && (rd_index <= LOG_LAST_IDX); // RULE_21
  always_comb begin
    nxt_rd = rd_hit ? ent_ff[rel[3:0]] : EVT_NONE; // RULE_21
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ff <= EVT_NONE;
    end else begin
      rd_ff <= nxt_rd;
    end
  end
  assign rd_data = rd_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_log_newest: assert property (evt_valid |=> ent_ff[0] == $past(evt_code)) // RULE_20
    else $error("newest log entry not stored");
  a_log_window: assert property (!rd_hit |=> rd_data == EVT_NONE) // RULE_21
    else $error("read outside log window not zero");
endmodule : gpdu_evlog
`default_nettype wire

// *** core/gpdu_top.sv ***
// Cyclic process-data front end of a two-finger gripper
`default_nettype none
// What this block does
// RULE_01: Both cyclic words move most significant byte first.
// RULE_02: Command word is two bytes: flags high, grip index low.
// RULE_03: Bits 15..13 pick one of eight light-ring patterns.
// RULE_04: Retention arm engages force retention on entering holding.
// RULE_05: Spare command bit 11 is ignored; master sends zero.
// RULE_06: Reference run starts when bit 10 and drive enable are set.
// RULE_07: Master keeps bit 10 low in normal operation.
// RULE_08: Drive enable gates motion; clear means drive off, no force.
// RULE_09: Grip bit set grips with indexed grip; clear releases.
// RULE_10: Jaw direction comes from release and no-part limits.
// RULE_11: Bits 7..0 are the grip index for the next grip.
// RULE_12: Status word is four bytes.
// RULE_13: Status 31..16 is signed jaw position in 1/100 mm.
// RULE_14: Status 15..8: switches 3..0, dropped, retention ack, spare, moving.
// RULE_15: Status 7..0: service, warning, overheat, fault, hold, no-part, released, inactive.
// RULE_16: Settling inside the part window moves released to holding.
// RULE_17: Virtual position switches report jaw position ranges.
// RULE_18: Maintenance and lubrication due raise events autonomously.
// RULE_19: Remaining cycles to next maintenance are readable.
// RULE_20: Ten most recent events and grip cycle count are kept; the log drops lower-priority events of the same cycle.
// RULE_21: Log entries read at indices 0x100 through 0x109.
// RULE_22: Dropped flag sets on holding to no-part, clears on release.
// RULE_23: Holding needs jaws blocked between limits with force built.
// RULE_24: Thermal warning below 0 or above 55 C, 2 C hysteresis.
// RULE_25: Overheat sets above 70 C, clears below 68 C.
// RULE_26: Command latched whole; status snapshot taken once per cycle.
// RULE_27: Status bit 10 echoes the retention arm bit.
module gpdu_top
  import gpdu_pkg::*;
(
  input wire logic CLK, // Device clock, 200 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic RX_VALID, // Command byte strobe
  input wire logic RX_FIRST, // Marks first byte of a command frame
  input wire logic [7:0] RX_BYTE, // Command byte
  input wire logic CYCLE_STROBE, // Start of a status cycle
  input wire logic TX_ADV, // Current status byte consumed
  output logic [7:0] TX_BYTE, // Status byte, MSB first
  input wire logic signed [15:0] JAW_POS, // Jaw position, 1/100 mm
  input wire logic signed [15:0] REL_LIMIT, // Release limit
  input wire logic signed [15:0] NOPART_LIMIT, // No-part limit
  input wire logic signed [15:0] WIN_LO, // Part window low edge
  input wire logic signed [15:0] WIN_HI, // Part window high edge
  input wire logic JAW_BLOCKED, // Jaws stopped against a part
  input wire logic FORCE_BUILT, // Grip force reached
  input wire logic JAWS_MOVING, // Motion in progress
  input wire logic [3:0] VSW_IN, // Virtual position switch hits
  input wire logic signed [7:0] TEMP_C, // Internal temperature
  input wire logic DEV_FAULT, // Device fault from monitors
  input wire logic SERVICE_ACK, // Service acknowledge pulse
  input wire logic [15:0] LOG_INDEX, // Log parameter index
  output logic [7:0] LOG_DATA, // Log entry
  output logic LOG_HIT, // Index inside log window
  output logic [2:0] LIGHT_PATTERN_SEL, // Light pattern select
  output logic DRIVE_EN, // Drive power enable
  output logic REF_RUN, // Reference run request
  output logic GRIP_REQ, // Grip (1) or release (0)
  output logic [7:0] GRIP_IDX, // Grip index for next grip
  output logic MOVE_UP, // Jaw travel toward higher position
  output logic RETENTION_ON, // Force retention engaged
  output logic [31:0] GRIP_COUNT, // Gripping cycle count
  output logic [31:0] SERVICE_DUE_REMAIN, // Cycles to next service
  output logic SERVICE_EVT, // Service due event pulse
  output logic LUBE_EVT // Lubrication due event pulse
);
  gpdu_cmd_t cmd_ff, nxt_cmd;
  logic [7:0] hi_ff, nxt_hi;
  logic half_ff, nxt_half;
  gpdu_state_t st_ff, nxt_st;
  logic drop_ff, nxt_drop, warn_ff, nxt_warn, hot_ff, nxt_hot;
  logic svc_ff, nxt_svc, fault_d_ff;
  logic [31:0] gcnt_ff, nxt_gcnt, mrem_ff, nxt_mrem, lrem_ff, nxt_lrem;
  gpdu_stat_t stat_ff, nxt_stat, live;
  logic [1:0] tx_idx_ff, nxt_tx_idx;
  logic [7:0] tx_ff, nxt_tx;
  logic dir_up, at_nopart, at_release, in_limits, hold_ok;
  logic grip_entry, evt_v, svc_hit, lube_hit;
  logic [7:0] evt_code;

  // Pick byte n of a status word, byte 0 being the most significant
  function automatic logic [7:0] stat_byte(input gpdu_stat_t s, input logic [1:0] n);
    logic [31:0] w;
    w = s;
    stat_byte = w[31 - 8 * n -: 8]; // RULE_01
  endfunction : stat_byte

  // Command receive: high byte first, word taken only when complete
  always_comb begin
    nxt_hi = hi_ff;
    nxt_half = half_ff;
    nxt_cmd = cmd_ff;
    if (RX_VALID) begin
      if (RX_FIRST) begin
        nxt_hi = RX_BYTE; // RULE_01
        nxt_half = 1'b1;
      end else if (half_ff) begin
        nxt_cmd = {hi_ff, RX_BYTE}; // RULE_02 RULE_26
        nxt_half = 1'b0;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      hi_ff <= 8'h00;
      half_ff <= 1'b0;
      cmd_ff <= '0;
    end else begin
      hi_ff <= nxt_hi;
      half_ff <= nxt_half;
      cmd_ff <= nxt_cmd;
    end
  end

  // Command decode; spare bit is never read
  assign LIGHT_PATTERN_SEL = cmd_ff.light_pattern_sel; // RULE_03 RULE_05
  assign DRIVE_EN = cmd_ff.drive_en; // RULE_08
  assign REF_RUN = cmd_ff.ref_req && cmd_ff.drive_en; // RULE_06 RULE_07
  assign GRIP_REQ = cmd_ff.drive_en && cmd_ff.grip_req; // RULE_09
  assign GRIP_IDX = cmd_ff.grip_idx; // RULE_11

  // Travel direction and limit checks from stored limits
  assign dir_up = NOPART_LIMIT > REL_LIMIT; // RULE_10
  assign MOVE_UP = cmd_ff.grip_req ? dir_up : !dir_up; // RULE_10
  assign at_nopart = dir_up ? (JAW_POS >= NOPART_LIMIT) : (JAW_POS <= NOPART_LIMIT);
  assign at_release = dir_up ? (JAW_POS <= REL_LIMIT) : (JAW_POS >= REL_LIMIT);
  assign in_limits = !at_nopart && !at_release;
  assign hold_ok = JAW_BLOCKED && FORCE_BUILT && in_limits && (JAW_POS >= WIN_LO) && (JAW_POS <= WIN_HI); // RULE_16 RULE_23

  // Grip state machine
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_INACTIVE: begin
        if (cmd_ff.drive_en) begin
          nxt_st = ST_RELEASED;
        end
      end
      ST_RELEASED, ST_NOPART: begin
        if (cmd_ff.grip_req && hold_ok) begin
          nxt_st = ST_HOLDING; // RULE_16
        end else if (cmd_ff.grip_req && at_nopart) begin
          nxt_st = ST_NOPART;
        end else if (!cmd_ff.grip_req && at_release) begin
          nxt_st = ST_RELEASED;
        end
      end
      ST_HOLDING: begin
        if (!cmd_ff.grip_req && at_release) begin
          nxt_st = ST_RELEASED;
        end else if (at_nopart) begin
          nxt_st = ST_NOPART;
        end
      end
      default: nxt_st = ST_INACTIVE;
    endcase
    if (!cmd_ff.drive_en) begin
      nxt_st = ST_INACTIVE; // RULE_08
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_ff <= ST_INACTIVE;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign RETENTION_ON = (st_ff == ST_HOLDING) && cmd_ff.retention_arm; // RULE_04
  assign grip_entry = (nxt_st == ST_HOLDING) && (st_ff != ST_HOLDING);

  // Flags: dropped part, thermal warning, overheat; set wins over clear
  always_comb begin
    nxt_drop = drop_ff;
    if (!cmd_ff.grip_req) begin
      nxt_drop = 1'b0; // RULE_22
    end
    if (st_ff == ST_HOLDING && nxt_st == ST_NOPART) begin
      nxt_drop = 1'b1; // RULE_22
    end
    nxt_warn = warn_ff;
    if (TEMP_C < WARN_LO_C || TEMP_C > WARN_HI_C) begin
      nxt_warn = 1'b1; // RULE_24
    end else if (TEMP_C >= WARN_LO_C + WARN_HYST_C && TEMP_C <= WARN_HI_C - WARN_HYST_C) begin
      nxt_warn = 1'b0; // RULE_24
    end
    nxt_hot = hot_ff;
    if (TEMP_C > FAULT_SET_C) begin
      nxt_hot = 1'b1; // RULE_25
    end else if (TEMP_C < FAULT_CLR_C) begin
      nxt_hot = 1'b0; // RULE_25
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      drop_ff <= 1'b0;
      warn_ff <= 1'b0;
      hot_ff <= 1'b0;
      fault_d_ff <= 1'b0;
    end else begin
      drop_ff <= nxt_drop;
      warn_ff <= nxt_warn;
      hot_ff <= nxt_hot;
      fault_d_ff <= DEV_FAULT;
    end
  end

  // Grip cycle count and service countdowns
  assign svc_hit = grip_entry && (mrem_ff == 32'h0000_0001);
  assign lube_hit = grip_entry && (lrem_ff == 32'h0000_0001);
  always_comb begin
    nxt_gcnt = grip_entry ? gcnt_ff + 32'h0000_0001 : gcnt_ff; // RULE_20
    nxt_mrem = mrem_ff;
    nxt_lrem = lrem_ff;
    nxt_svc = svc_ff;
    if (grip_entry && mrem_ff != 32'h0000_0000) begin
      nxt_mrem = mrem_ff - 32'h0000_0001; // RULE_19
    end
    if (grip_entry) begin
      nxt_lrem = lube_hit ? LUBE_INTERVAL : lrem_ff - 32'h0000_0001;
    end
    if (SERVICE_ACK) begin
      nxt_svc = 1'b0;
      nxt_mrem = SERVICE_DUE_INTERVAL;
    end
    if (svc_hit) begin
      nxt_svc = 1'b1; // RULE_18
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      gcnt_ff <= 32'h0000_0000;
      mrem_ff <= SERVICE_DUE_INTERVAL;
      lrem_ff <= LUBE_INTERVAL;
      svc_ff <= 1'b0;
    end else begin
      gcnt_ff <= nxt_gcnt;
      mrem_ff <= nxt_mrem;
      lrem_ff <= nxt_lrem;
      svc_ff <= nxt_svc;
    end
  end
  assign GRIP_COUNT = gcnt_ff;
  assign SERVICE_DUE_REMAIN = mrem_ff; // RULE_19
  assign SERVICE_EVT = svc_hit; // RULE_18
  assign LUBE_EVT = lube_hit; // RULE_18

  // One event per cycle into the log, highest priority first
  always_comb begin
    evt_code = EVT_NONE;
    if (DEV_FAULT && !fault_d_ff) begin
      evt_code = EVT_FAULT;
    end else if (nxt_hot && !hot_ff) begin
      evt_code = EVT_OVERHEAT;
    end else if (nxt_drop && !drop_ff) begin
      evt_code = EVT_DROPPED;
    end else if (svc_hit) begin
      evt_code = EVT_SERVICE;
    end else if (lube_hit) begin
      evt_code = EVT_LUBE;
    end
  end
  assign evt_v = evt_code != EVT_NONE;

  gpdu_evlog u_log (
    .clk(CLK),
    .rst(RST),
    .evt_valid(evt_v),
    .evt_code(evt_code),
    .rd_index(LOG_INDEX),
    .rd_data(LOG_DATA),
    .rd_hit(LOG_HIT)
  );

  // Live status assembly
  always_comb begin
    live = '0;
    live.jaw_pos = JAW_POS; // RULE_13
    {live.virtual_switch_three, live.virtual_switch_two,
     live.virtual_switch_one, live.virtual_switch_zero} = VSW_IN; // RULE_14 RULE_17
    live.workpiece_dropped = drop_ff;
    live.retention_ack = cmd_ff.retention_arm; // RULE_27
    live.spare_bit = 1'b0;
    live.jaws_moving = JAWS_MOVING;
    live.service_due = svc_ff; // RULE_15
    live.thermal_warning = warn_ff;
    live.overheat_flag = hot_ff;
    live.dev_fault = DEV_FAULT;
    live.holding = st_ff == ST_HOLDING; // RULE_23
    live.empty_grip_flag = st_ff == ST_NOPART;
    live.released = st_ff == ST_RELEASED;
    live.inactive = st_ff == ST_INACTIVE;
  end

  // Snapshot once per cycle and shift out MSB first
  always_comb begin
    nxt_stat = stat_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_tx = tx_ff;
    if (CYCLE_STROBE) begin
      nxt_stat = live; // RULE_26 RULE_12
      nxt_tx_idx = 2'd0;
      nxt_tx = stat_byte(live, 2'd0); // RULE_01
    end else if (TX_ADV && tx_idx_ff != 2'(STAT_BYTES - 3'd1)) begin
      nxt_tx_idx = tx_idx_ff + 2'd1;
      nxt_tx = stat_byte(stat_ff, tx_idx_ff + 2'd1); // RULE_01
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_ff <= '0;
      tx_idx_ff <= 2'd0;
      tx_ff <= 8'h00;
    end else begin
      stat_ff <= nxt_stat;
      tx_idx_ff <= nxt_tx_idx;
      tx_ff <= nxt_tx;
    end
  end
  assign TX_BYTE = tx_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_cmd_word_order: assert property (RX_VALID && RX_FIRST ##1 RX_VALID && !RX_FIRST
      |=> cmd_ff == {$past(RX_BYTE, 2), $past(RX_BYTE)}) // RULE_02
    else $error("command word not assembled high byte first");
  a_tx_msb_first: assert property (CYCLE_STROBE |=> TX_BYTE == stat_ff[31:24]) // RULE_01
    else $error("first status byte is not the MSB");
  a_ref_run_gate: assert property (REF_RUN |-> DRIVE_EN && cmd_ff[10]) // RULE_06
    else $error("reference run without enable");
  a_drive_off_idle: assert property (!cmd_ff.drive_en |=> st_ff == ST_INACTIVE) // RULE_08
    else $error("state not inactive while drive disabled");
  a_retention_eng: assert property (st_ff == ST_HOLDING && cmd_ff.retention_arm |-> RETENTION_ON) // RULE_04
    else $error("retention not engaged in holding");
  a_drop_set: assert property (st_ff == ST_HOLDING && nxt_st == ST_NOPART |=> drop_ff) // RULE_22
    else $error("dropped flag not set");
  a_drop_clear: assert property (drop_ff && !cmd_ff.grip_req && st_ff != ST_HOLDING |=> !drop_ff) // RULE_22
    else $error("dropped flag not cleared on release");
  a_hot_set: assert property (TEMP_C > FAULT_SET_C |=> hot_ff) // RULE_25
    else $error("overheat flag not set above limit");
  a_warn_band: assert property ((TEMP_C > WARN_HI_C |=> warn_ff) and // RULE_24
      (warn_ff && TEMP_C > WARN_HI_C - WARN_HYST_C |=> warn_ff))
    else $error("warning released inside hysteresis");
  a_retention_ack: assert property (CYCLE_STROBE |=> stat_ff.retention_ack == $past(cmd_ff.retention_arm)) // RULE_27
    else $error("retention ack not echoed");
  a_hold_cause: assert property ($rose(st_ff == ST_HOLDING) |-> $past(hold_ok)) // RULE_23 RULE_16
    else $error("holding entered without blocked jaws");
  a_service_due: assert property (svc_hit && !SERVICE_ACK |=> svc_ff) // RULE_18
    else $error("service flag not raised");
  c_grip_hold: cover property (st_ff == ST_RELEASED ##[1:50] st_ff == ST_HOLDING);
  c_part_lost: cover property (st_ff == ST_HOLDING ##1 st_ff == ST_NOPART);
  c_full_tx: cover property (CYCLE_STROBE ##1 TX_ADV [*3]);
endmodule : gpdu_top
`default_nettype wire

// *** dv/gpdu_master_model.sv ***
// Master-side model: sends command words and collects status words
`default_nettype none
module gpdu_master_model
  import gpdu_pkg::*;
(
  input wire logic clk, // Device clock
  output logic rx_valid, // Command byte strobe
  output logic rx_first, // First byte marker
  output logic [7:0] rx_byte, // Command byte
  output logic cycle_strobe, // Status snapshot request
  output logic tx_adv, // Status byte consumed
  input wire logic [7:0] tx_byte // Status byte from the device
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels at time zero
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_byte = 8'h00;
    cycle_strobe = 1'b0;
    tx_adv = 1'b0;
  end
  // Command word goes out high byte first, then low byte
  task automatic send_cmd(input gpdu_cmd_t cmd);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_first = 1'b1;
    rx_byte = cmd[15:8];
    @(negedge clk);
    rx_first = 1'b0;
    rx_byte = cmd[7:0];
    @(negedge clk);
    rx_valid = 1'b0;
    // A released byte lane shows no stale copy of the last byte
    rx_byte = ~rx_byte;
  endtask : send_cmd
  // Snapshot request, then four status bytes most significant first
  task automatic read_stat(output logic [31:0] st);
    @(negedge clk);
    cycle_strobe = 1'b1;
    @(negedge clk);
    cycle_strobe = 1'b0;
    tx_adv = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      st[i*8 +: 8] = tx_byte;
      if (i > 0) @(negedge clk);
    end
    tx_adv = 1'b0;
  endtask : read_stat
endmodule : gpdu_master_model
`default_nettype wire

// *** dv/gpdu_top_test.sv ***
// Self-checking bench for the gripper process-data unit
`default_nettype none
module gpdu_top_test
  import gpdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid, rx_first, cycle_strobe, tx_adv;
  logic [7:0] rx_byte, tx_byte, log_data, grip_idx;
  logic signed [15:0] jaw_pos, rel_limit, nopart_limit, win_lo, win_hi;
  logic jaw_blocked, force_built, jaws_moving, dev_fault, service_ack;
  logic [3:0] vsw_in;
  logic signed [7:0] temp_c;
  logic [15:0] log_index;
  logic log_hit, drive_en, ref_run, grip_req, move_up, retention_on;
  logic svc_evt, lube_evt;
  logic [2:0] light;
  logic [31:0] grip_count, service_due_remain, st;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic signed [7:0] tt [10] = '{8'sh38, 8'sh36, 8'sh35, 8'shFF, 8'sh01, 8'sh02, 8'sh47, 8'sh45, 8'sh43, 8'sh19};
  logic [1:0] te [10] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2, 2'h0};
  // Clock, 5 ns period
  always #2.5 clk = ~clk;
  gpdu_master_model u_master (.clk(clk), .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte),
    .cycle_strobe(cycle_strobe), .tx_adv(tx_adv), .tx_byte(tx_byte));
  gpdu_top u_dut (.CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_FIRST(rx_first), .RX_BYTE(rx_byte),
    .CYCLE_STROBE(cycle_strobe), .TX_ADV(tx_adv), .TX_BYTE(tx_byte), .JAW_POS(jaw_pos),
    .REL_LIMIT(rel_limit), .NOPART_LIMIT(nopart_limit), .WIN_LO(win_lo), .WIN_HI(win_hi),
    .JAW_BLOCKED(jaw_blocked), .FORCE_BUILT(force_built), .JAWS_MOVING(jaws_moving), .VSW_IN(vsw_in),
    .TEMP_C(temp_c), .DEV_FAULT(dev_fault), .SERVICE_ACK(service_ack), .LOG_INDEX(log_index),
    .LOG_DATA(log_data), .LOG_HIT(log_hit), .LIGHT_PATTERN_SEL(light), .DRIVE_EN(drive_en),
    .REF_RUN(ref_run), .GRIP_REQ(grip_req), .GRIP_IDX(grip_idx), .MOVE_UP(move_up),
    .RETENTION_ON(retention_on), .GRIP_COUNT(grip_count), .SERVICE_DUE_REMAIN(service_due_remain),
    .SERVICE_EVT(svc_evt), .LUBE_EVT(lube_evt));
  // Value comparison with mismatch report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Counts and verdict, then stop
  task automatic wrap_up;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Command word with spare and reference bits low
  function automatic gpdu_cmd_t mk(input logic [2:0] pat, input logic ret, en, grip, input logic [7:0] idx);
    return {pat, ret, 1'b0, 1'b0, en, grip, idx};
  endfunction : mk
  // Send a word and let the decoded outputs land
  task automatic cmd(input gpdu_cmd_t c);
    u_master.send_cmd(c);
    @(negedge clk);
  endtask : cmd
  // Poll the status word under a bound until the masked bits match
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 20; i++) begin
      u_master.read_stat(st);
      if ((st & m) === v) break;
    end
    chk(st & m, v);
  endtask : wait_st
  // Log read: window hit at once, entry one cycle later
  task automatic rd_log(input logic [15:0] idx, input logic hit, input logic [7:0] d);
    @(negedge clk);
    log_index = idx;
    #1 chk(log_hit, hit);
    @(negedge clk);
    chk(log_data, d);
  endtask : rd_log
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    jaw_pos = 16'shFE0C;
    rel_limit = 16'sh0064;
    nopart_limit = 16'sh03E8;
    win_lo = 16'sh0190;
    win_hi = 16'sh0258;
    {jaw_blocked, force_built, jaws_moving, dev_fault, service_ack} = 5'h00;
    vsw_in = 4'hA;
    temp_c = 8'sh19;
    log_index = 16'h0100;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(drive_en, 1'b0);
    chk(grip_count, 32'h0000_0000);
    chk(service_due_remain, SERVICE_DUE_INTERVAL);
    rd_log(16'h0100, 1'b1, EVT_NONE);
    wait_st(32'hFFFF_00FF, 32'hFE0C_0001);
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      cmd(mk(p[2:0], p[0], 1'b1, p[1], 8'hF0 + p[7:0]));
      chk(light, p[2:0]);
      chk(grip_idx, 8'hF0 + p[7:0]);
      chk(drive_en, 1'b1);
      chk(grip_req, p[1]);
      chk(ref_run, 1'b0);
    end
    cmd(mk(3'h0, 1'b0, 1'b0, 1'b1, 8'h00));
    chk({drive_en, grip_req}, 2'h0);
    cmd(mk(3'h5, 1'b0, 1'b1, 1'b0, 8'h12) | 16'h0800);
    chk({light, drive_en, grip_idx}, {3'h5, 1'b1, 8'h12});
    cmd(mk(3'h0, 1'b0, 1'b1, 1'b0, 8'h00) | 16'h0400);
    chk(ref_run, 1'b1);
    cmd(16'h0400);
    chk(ref_run, 1'b0);
    $display("test decode done");
    for (int k = 0; k < 4; k++) begin
      rel_limit = k[1] ? 16'sh03E8 : 16'sh0064;
      nopart_limit = k[1] ? 16'sh0064 : 16'sh03E8;
      cmd(mk(3'h0, 1'b0, 1'b1, k[0], 8'h00));
      chk(move_up, k[0] ^ k[1]);
    end
    $display("test direction done");
    // Restore the limits and release while the jaws sit past the release limit
    rel_limit = 16'sh0064;
    nopart_limit = 16'sh03E8;
    jaws_moving = 1'b1;
    cmd(mk(3'h2, 1'b1, 1'b1, 1'b0, 8'h03));
    jaw_pos = 16'sh01F4;
    wait_st(32'hFFFF_FFFF, 32'h01F4_A502);
    {jaw_blocked, force_built} = 2'h3;
    cmd(mk(3'h2, 1'b1, 1'b1, 1'b1, 8'h03));
    wait_st(32'h0000_04FF, 32'h0000_0408);
    chk(retention_on, 1'b1);
    chk(grip_count, 32'h0000_0001);
    chk(service_due_remain, SERVICE_DUE_INTERVAL - 32'h0000_0001);
    chk({svc_evt, lube_evt}, 2'h0);
    // Service acknowledge reloads the countdown
    service_ack = 1'b1;
    @(negedge clk);
    service_ack = 1'b0;
    chk(service_due_remain, SERVICE_DUE_INTERVAL);
    $display("test holding done");
    {jaw_blocked, force_built} = 2'h0;
    jaw_pos = 16'sh03E8;
    wait_st(32'h0000_080F, 32'h0000_0804);
    chk(retention_on, 1'b0);
    rd_log(16'h0100, 1'b1, EVT_DROPPED);
    cmd(mk(3'h2, 1'b1, 1'b1, 1'b0, 8'h03));
    jaw_pos = 16'sh0064;
    wait_st(32'h0000_0800, 32'h0000_0000);
    $display("test dropped done");
    for (int j = 0; j < 10; j++) begin
      temp_c = tt[j];
      wait_st(32'h0000_0060, {25'h0, te[j], 5'h00});
    end
    dev_fault = 1'b1;
    wait_st(32'h0000_0010, 32'h0000_0010);
    rd_log(16'h0100, 1'b1, EVT_FAULT);
    rd_log(16'h0101, 1'b1, EVT_OVERHEAT);
    rd_log(16'h0102, 1'b1, EVT_DROPPED);
    rd_log(16'h0109, 1'b1, EVT_NONE);
    rd_log(16'h010A, 1'b0, 8'h00);
    rd_log(16'h00FF, 1'b0, 8'h00);
    $display("test thermal and log done");
    wrap_up();
  end
endmodule : gpdu_top_test
`default_nettype wire
